// ===== core/tcu_timer_control.sv
`timescale 1ns/1ps
module tcu_timer_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        capture_strobe,
    input  wire logic        capture_dual_edge,
    input  wire logic        capture_level,
    input  wire logic        run_trigger,
    output logic             sample_tick,
    output logic             irq
);
    // =========================================================
    // bus decode
    // =========================================================
    tcu_pkg::tcu_ctrl_t    ctrl_reg;
    tcu_pkg::tcu_capture_t cap_next;
    logic [15:0] reload_reg;
    logic [15:0] reload_shadow_reg;
    logic [15:0] count_reg;
    logic [15:0] compare_reg;
    logic [16:0] capture_reg;
    logic [1:0]  chmode_reg;
    logic        counting_down_reg;
    logic        overflowed_reg;
    logic [tcu_pkg::ST_WIDTH-1:0] status_reg;
    logic [tcu_pkg::ST_WIDTH-1:0] mask_reg;
    logic [tcu_pkg::ST_WIDTH-1:0] events;
    logic        wr;
    logic        rd;
    logic        tick;
    logic        update_evt;
    logic        compare_evt;
    logic        flag_ok;
    logic        eff_down;
    logic        mapped;
    logic [31:0] prdata_next;

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wr && (paddr == off);
    endfunction

    // =========================================================
    // control word layout
    // =========================================================
    // the struct holds only implemented bits, so reserved and
    // unmodelled low bits fall out as zero on every read
    function automatic logic [15:0] ctrl_pack(
        input tcu_pkg::tcu_ctrl_t c
    );
        ctrl_pack                           = 16'h0000;
        ctrl_pack[tcu_pkg::LEVEL_BIT]       = c.level_en;
        ctrl_pack[tcu_pkg::SATURATE_BIT]    = c.saturate;
        ctrl_pack[tcu_pkg::DIVIDE_LSB +: 2] = c.divide;
        ctrl_pack[tcu_pkg::PRELOAD_BIT]     = c.preload;
        ctrl_pack[tcu_pkg::ALIGN_LSB +: 2]  = c.align;
        ctrl_pack[tcu_pkg::DIR_BIT]         = c.down;
        ctrl_pack[tcu_pkg::RUN_BIT]         = c.run;
    endfunction

    function automatic tcu_pkg::tcu_ctrl_t ctrl_unpack(
        input logic [15:0] w
    );
        ctrl_unpack.level_en = w[tcu_pkg::LEVEL_BIT];
        ctrl_unpack.saturate = w[tcu_pkg::SATURATE_BIT];
        ctrl_unpack.divide   = w[tcu_pkg::DIVIDE_LSB +: 2];
        ctrl_unpack.preload  = w[tcu_pkg::PRELOAD_BIT];
        ctrl_unpack.align    =
            tcu_pkg::tcu_align_t'(w[tcu_pkg::ALIGN_LSB +: 2]);
        ctrl_unpack.down     = w[tcu_pkg::DIR_BIT];
        ctrl_unpack.run      = w[tcu_pkg::RUN_BIT];
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign mapped = paddr inside {tcu_pkg::CTRL_OFFSET,
        tcu_pkg::RELOAD_OFFSET, tcu_pkg::COUNT_OFFSET,
        tcu_pkg::COMPARE_OFFSET, tcu_pkg::CAPTURE_OFFSET,
        tcu_pkg::STATUS_OFFSET, tcu_pkg::MASK_OFFSET,
        tcu_pkg::CHMODE_OFFSET};

    // zero wait states: pready raised in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // read mux; unused upper bits stay zero
    always_comb begin
        prdata_next = 32'h0000_0000;
        unique case (paddr)
            tcu_pkg::CTRL_OFFSET:
                prdata_next[15:0] = ctrl_pack(ctrl_reg) &
                    tcu_pkg::CTRL_WMASK;
            tcu_pkg::RELOAD_OFFSET:  prdata_next[15:0] = reload_reg;
            tcu_pkg::COUNT_OFFSET:   prdata_next[15:0] = count_reg;
            tcu_pkg::COMPARE_OFFSET: prdata_next[15:0] = compare_reg;
            tcu_pkg::CAPTURE_OFFSET: prdata_next[16:0] = capture_reg;
            tcu_pkg::STATUS_OFFSET:
                prdata_next[tcu_pkg::ST_WIDTH-1:0] = status_reg;
            tcu_pkg::MASK_OFFSET:
                prdata_next[tcu_pkg::ST_WIDTH-1:0] = mask_reg;
            tcu_pkg::CHMODE_OFFSET:  prdata_next[1:0] = chmode_reg;
            default:                 prdata_next = 32'h0000_0000;
        endcase
    end

    // read data registered in setup, valid in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            prdata <= prdata_next;
        end
    end

    // =========================================================
    // configuration registers
    // =========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ctrl_unpack(tcu_pkg::CTRL_RESET);
        end else if (wr_to(tcu_pkg::CTRL_OFFSET)) begin
            // reserved bits 13:10 dropped on write
            ctrl_reg <= ctrl_unpack(pwdata[15:0]);
        end else if (run_trigger) begin
            ctrl_reg.run <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_reg <= 16'h0000;
            chmode_reg  <= 2'h0;
            mask_reg    <= '0;
        end else begin
            if (wr_to(tcu_pkg::COMPARE_OFFSET)) begin
                compare_reg <= pwdata[15:0];
            end
            if (wr_to(tcu_pkg::CHMODE_OFFSET)) begin
                chmode_reg <= pwdata[1:0];
            end
            if (wr_to(tcu_pkg::MASK_OFFSET)) begin
                mask_reg <= pwdata[tcu_pkg::ST_WIDTH-1:0];
            end
        end
    end

    // software-visible reload; shadow is what the counter uses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_reg        <= tcu_pkg::RELOAD_RESET;
            reload_shadow_reg <= tcu_pkg::RELOAD_RESET;
        end else begin
            if (wr_to(tcu_pkg::RELOAD_OFFSET)) begin
                reload_reg <= pwdata[15:0];
            end
            if (!ctrl_reg.preload) begin
                reload_shadow_reg <= wr_to(tcu_pkg::RELOAD_OFFSET) ?
                    pwdata[15:0] : reload_reg;
            end else if (update_evt) begin
                reload_shadow_reg <= reload_reg;
            end
        end
    end

    // =========================================================
    // sampling clock
    // =========================================================
    tcu_tick_divider u_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .divide  (ctrl_reg.divide),
        .tick    (tick)
    );

    // one tick feeds both dead-time and input filters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= tick;
        end
    end

    // =========================================================
    // counter
    // =========================================================
    // direction bit only matters in edge-aligned mode
    assign eff_down = (ctrl_reg.align == tcu_pkg::TCU_EDGE) ?
        ctrl_reg.down : counting_down_reg;

    // centre modes flag one count early so the turn lands on
    // the reload value and on zero, not one step past them
    always_comb begin
        update_evt = 1'b0;
        if (ctrl_reg.run) begin
            if (ctrl_reg.align == tcu_pkg::TCU_EDGE) begin
                update_evt = eff_down ? (count_reg == 16'h0000)
                    : (count_reg >= reload_shadow_reg);
            end else begin
                update_evt = counting_down_reg ?
                    (count_reg <= 16'h0001)
                    : (count_reg >= reload_shadow_reg - 16'h0001);
            end
        end
    end

    // turn-around state; edge mode just mirrors the direction bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counting_down_reg <= 1'b0;
        end else if (ctrl_reg.run && !wr_to(tcu_pkg::COUNT_OFFSET)) begin
            if (ctrl_reg.align == tcu_pkg::TCU_EDGE) begin
                counting_down_reg <= ctrl_reg.down;
            end else if (update_evt) begin
                counting_down_reg <= !counting_down_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 16'h0000;
        end else if (wr_to(tcu_pkg::COUNT_OFFSET)) begin
            count_reg <= pwdata[15:0];
        end else if (ctrl_reg.run) begin
            unique case (ctrl_reg.align)
                tcu_pkg::TCU_EDGE: begin
                    if (!eff_down) begin
                        count_reg <= update_evt ? 16'h0000
                            : count_reg + 16'h0001;
                    end else begin
                        count_reg <= update_evt ? reload_shadow_reg
                            : count_reg - 16'h0001;
                    end
                end
                default: begin
                    // turn around at the reload value and at zero
                    if (!counting_down_reg) begin
                        count_reg <= count_reg + 16'h0001;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // compare flag gating
    // =========================================================
    always_comb begin
        unique case (ctrl_reg.align)
            tcu_pkg::TCU_EDGE:    flag_ok = 1'b1;
            tcu_pkg::TCU_CENTER1: flag_ok = eff_down;
            tcu_pkg::TCU_CENTER2: flag_ok = !eff_down;
            tcu_pkg::TCU_CENTER3: flag_ok = 1'b1;
        endcase
    end

    // only a compare-output channel has a compare flag at all
    assign compare_evt = ctrl_reg.run && (count_reg == compare_reg)
        && (chmode_reg == tcu_pkg::DIR_COMPARE) && flag_ok;

    // =========================================================
    // capture
    // =========================================================
    // overflow seen since the last capture; a capture in the
    // overflow cycle already saturates, so it consumes that one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflowed_reg <= 1'b0;
        end else if (capture_strobe) begin
            overflowed_reg <= 1'b0;
        end else if (update_evt) begin
            overflowed_reg <= 1'b1;
        end
    end

    always_comb begin
        cap_next.valid = capture_strobe &&
            (chmode_reg != tcu_pkg::DIR_COMPARE);
        cap_next.value = {1'b0, count_reg};
        if (ctrl_reg.saturate && (overflowed_reg || update_evt)) begin
            cap_next.value[15:0] = tcu_pkg::SATURATE_VALUE;
        end
        if (ctrl_reg.level_en && capture_dual_edge) begin
            cap_next.value[tcu_pkg::CAP_LEVEL_BIT] = capture_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_reg <= 17'h0_0000;
        end else if (cap_next.valid) begin
            capture_reg <= cap_next.value;
        end
    end

    // =========================================================
    // interrupt status
    // =========================================================
    assign events = {cap_next.valid, compare_evt, update_evt};

    // set wins over a same-cycle write-one clear, so an event
    // landing on the clear write is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(wr_to(tcu_pkg::STATUS_OFFSET)
                ? pwdata[tcu_pkg::ST_WIDTH-1:0] : '0)) | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_reg | events) & mask_reg);
        end
    end
endmodule // tcu_timer_control

// ===== core/tcu_pkg.sv
// Behaviour
// - level bit 16 reported on dual-edge capture
// - overflow mode off stores counter value
// - overflow mode on saturates to 0xFFFF
// - divide field: 1, 2, 4 clocks
// - dead-time and filters share divided tick
// - bit 7 enables reload preload
// - mode 00 edge-aligned, direction bit counts
// - mode 01 flags only counting down
// - mode 10 flags only counting up
// - mode 11 flags both directions
// - direction gating only for compare channels
// - direction bit ignored when centre-aligned
// - run bit starts and stops counting
package tcu_pkg;
    // =========================================================
    // register map (byte addresses)
    // =========================================================
    localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
    localparam logic [7:0]  RELOAD_OFFSET  = 8'h04;
    localparam logic [7:0]  COUNT_OFFSET   = 8'h08;
    localparam logic [7:0]  COMPARE_OFFSET = 8'h0C;
    localparam logic [7:0]  CAPTURE_OFFSET = 8'h10;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h14;
    localparam logic [7:0]  MASK_OFFSET    = 8'h18;
    localparam logic [7:0]  CHMODE_OFFSET  = 8'h1C;
    // =========================================================
    // control fields
    // =========================================================
    localparam int          LEVEL_BIT      = 15;
    localparam int          SATURATE_BIT   = 14;
    localparam int          DIVIDE_LSB     = 8;
    localparam int          PRELOAD_BIT    = 7;
    localparam int          ALIGN_LSB      = 5;
    localparam int          DIR_BIT        = 4;
    localparam int          RUN_BIT        = 0;
    localparam logic [15:0] CTRL_WMASK     = 16'hC3F1;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] RELOAD_RESET   = 16'hFFFF;
    localparam logic [15:0] SATURATE_VALUE = 16'hFFFF;
    localparam int          CAP_LEVEL_BIT  = 16;
    // status bits
    localparam int          ST_UPDATE      = 0;
    localparam int          ST_COMPARE     = 1;
    localparam int          ST_CAPTURE     = 2;
    localparam int          ST_WIDTH       = 3;
    localparam logic [1:0]  DIR_COMPARE    = 2'h0;

    typedef enum logic [1:0] {
        TCU_EDGE    = 2'b00,
        TCU_CENTER1 = 2'b01,
        TCU_CENTER2 = 2'b10,
        TCU_CENTER3 = 2'b11
    } tcu_align_t;

    typedef struct packed {
        logic       level_en;
        logic       saturate;
        logic [1:0] divide;
        logic       preload;
        tcu_align_t align;
        logic       down;
        logic       run;
    } tcu_ctrl_t;

    typedef struct packed {
        logic        valid;
        logic [16:0] value;
    } tcu_capture_t;
endpackage

// ===== core/tcu_tick_divider.sv
`timescale 1ns/1ps
module tcu_tick_divider (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] divide,
    output logic            tick
);
    logic [1:0] count_reg;
    logic [1:0] limit;

    always_comb begin
        unique case (divide)
            2'h0:    limit = 2'h0;
            2'h1:    limit = 2'h1;
            2'h2:    limit = 2'h3;
            // reserved code: hold the slowest legal rate
            default: limit = 2'h3;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 2'h0;
            tick      <= 1'b0;
        end else begin
            tick <= (count_reg >= limit);
            if (count_reg >= limit) begin
                count_reg <= 2'h0;
            end else begin
                count_reg <= count_reg + 2'h1;
            end
        end
    end
endmodule // tcu_tick_divider

// ===== tb/tcu_timer_control_monitor.sv
`timescale 1ns/1ps
module tcu_timer_control_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        capture_strobe,
    input wire logic        capture_dual_edge,
    input wire logic        capture_level,
    input wire logic        run_trigger,
    input wire logic        sample_tick,
    input wire logic        irq
);
    logic [1:0] div_reg;
    logic [3:0] quiet_reg;
    logic       setup;
    logic       ctrl_wr;
    assign setup   = psel && !penable;
    assign ctrl_wr = psel && penable && pwrite
        && paddr == tcu_pkg::CTRL_OFFSET;
    // =========================================================
    // divide shadow; tick phase settles a few cycles after a write
    // =========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg   <= 2'h0;
            quiet_reg <= 4'h0;
        end else if (ctrl_wr) begin
            div_reg   <= pwdata[9:8];
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_NEXT: assert property (setup |=> pready)
        else $error("no ready after setup");
    AST_READY_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("slverr without ready");
    AST_UNMAPPED: assert property (setup && paddr > 8'h1C
        |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    AST_CTRL_ZERO: assert property (setup && !pwrite
        && paddr == tcu_pkg::CTRL_OFFSET
        |=> prdata[13:10] == 4'h0 && prdata[31:16] == 16'h0)
        else $error("reserved ctrl bits not zero");
    AST_TICK_ONE: assert property (quiet_reg > 4'h7
        && div_reg == 2'h0 |-> sample_tick)
        else $error("tick not every cycle");
    AST_TICK_TWO: assert property (quiet_reg > 4'h7
        && div_reg == 2'h1
        && sample_tick |=> !sample_tick ##1 sample_tick)
        else $error("tick not every two");
    AST_TICK_FOUR: assert property (quiet_reg > 4'h7 && div_reg[1]
        && sample_tick |=> !sample_tick [*3] ##1 sample_tick)
        else $error("tick not every four");
    cover property (capture_strobe && capture_dual_edge);
    cover property ($rose(irq));
    cover property (pslverr);
    cover property (div_reg == 2'h2 && sample_tick);
endmodule // tcu_timer_control_monitor

bind tcu_timer_control tcu_timer_control_monitor i_mon (.*);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        capture_strobe;
    logic        capture_dual_edge;
    logic        capture_level;
    logic        run_trigger;
    logic        sample_tick;
    logic        irq;
    logic [31:0] rdata;
    logic        rerr;
    int          failures;
    int          check_count;

    tcu_timer_control i_tcu_timer_control (.*);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // =========================================================
    // shared tasks
    // =========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic give_verdict();
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic capture(input logic lvl);
        capture_level <= lvl;
        capture_strobe <= 1'b1;
        @(posedge pclk);
        capture_strobe <= 1'b0;
        @(posedge pclk);
    endtask
    // =========================================================
    // scenarios
    // =========================================================
    task automatic t_regs();
        apb(0, 8'h00, 0);
        chk(rdata, 32'h0);
        apb(0, 8'h04, 0);
        chk(rdata, 32'hFFFF);
        apb(1, 8'h00, 32'hFFFF);
        apb(0, 8'h00, 0);
        chk(rdata, 32'hC3F1);
        apb(1, 8'h00, 32'h0);
        apb(1, 8'h24, 32'hFFFF);
        apb(0, 8'h24, 0);
        chk({rerr, rdata[30:0]}, 32'h8000_0000);
    endtask
    task automatic t_tick();
        int n;
        for (int d = 0; d < 4; d++) begin
            apb(1, 8'h00, 32'(d) << 8);
            repeat (6) @(posedge pclk);
            for (int k = 0; k < 2; k++) begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (sample_tick !== 1'b1 && n < 20);
            end
            chk(32'(n), d == 0 ? 1 : d == 1 ? 2 : 4);
        end
    endtask
    task automatic t_capture();
        apb(1, 8'h1C, 32'h1);
        apb(1, 8'h00, 32'h8000);
        apb(1, 8'h08, 32'h1234);
        capture_dual_edge <= 1'b1;
        capture(1'b1);
        apb(0, 8'h10, 0);
        chk(rdata, 32'h1_1234);
        apb(0, 8'h14, 0);
        chk(rdata & 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h0);
        apb(1, 8'h18, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1, 8'h14, 32'h7);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1, 8'h04, 32'h4);
        apb(1, 8'h08, 32'h0);
        apb(1, 8'h00, 32'h4001);
        repeat (12) @(posedge pclk);
        capture(1'b0);
        apb(0, 8'h10, 0);
        chk(rdata & 32'hFFFF, 32'hFFFF);
        apb(1, 8'h00, 32'h4000);
        capture(1'b0);
        apb(1, 8'h08, 32'h2);
        capture(1'b0);
        apb(0, 8'h10, 0);
        chk(rdata, 32'h2);
        apb(0, 8'h14, 0);
        chk(rdata & 32'h2, 32'h0);
    endtask
    task automatic t_run();
        logic [31:0] a;
        apb(1, 8'h00, 32'h0);
        run_trigger <= 1'b1;
        @(posedge pclk);
        run_trigger <= 1'b0;
        apb(0, 8'h00, 0);
        chk(rdata, 32'h1);
        apb(0, 8'h08, 0);
        a = rdata;
        apb(0, 8'h08, 0);
        chk({31'h0, a !== rdata}, 32'h1);
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h08, 0);
        a = rdata;
        apb(0, 8'h08, 0);
        chk(rdata, a);
    endtask
    task automatic t_align();
        logic [31:0] c;
        logic [31:0] e;
        apb(1, 8'h1C, 32'h0);
        apb(1, 8'h04, 32'h8);
        apb(1, 8'h0C, 32'h2);
        for (int m = 0; m < 4; m++) begin
            // direction bit set in centre modes must not matter
            c = (32'(m) << 5) | (m > 0 ? 32'h10 : 32'h0);
            apb(1, 8'h08, 32'h0);
            apb(1, 8'h14, 32'h7);
            apb(1, 8'h00, c | 32'h1);
            repeat (2) @(posedge pclk);
            apb(1, 8'h00, c);
            apb(0, 8'h14, 0);
            e = m == 1 ? 32'h0 : 32'h2;
            chk(rdata & 32'h2, e);
            apb(1, 8'h00, c | 32'h1);
            repeat (12) @(posedge pclk);
            apb(1, 8'h00, c);
            apb(0, 8'h14, 0);
            chk(rdata & 32'h2, 32'h2);
            apb(0, 8'h08, 0);
            chk({31'h0, rdata <= 32'h8}, 32'h1);
        end
    endtask
    task automatic t_preload();
        apb(1, 8'h00, 32'h80);
        apb(1, 8'h04, 32'h3);
        apb(1, 8'h08, 32'h5);
        apb(1, 8'h00, 32'h81);
        apb(0, 8'h08, 0);
        chk({31'h0, rdata > 32'h5}, 32'h1);
        repeat (10) @(posedge pclk);
        apb(1, 8'h00, 32'h80);
        apb(0, 8'h08, 0);
        chk({31'h0, rdata <= 32'h3}, 32'h1);
    endtask
    initial begin
        failures = 0;
        check_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {capture_strobe, capture_dual_edge, capture_level} = '0;
        run_trigger = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_tick();
        t_capture();
        t_run();
        t_align();
        t_preload();
        give_verdict();
    end
    // run needs well under 2000 cycles
    initial begin
        #(25 * 5000);
        failures++;
        give_verdict();
    end
endmodule // testbench
